// ---- irq_vec_consts.svh ----
/*
 Constants of the interrupt vector and mask unit: register offsets, flag bit
 positions, trap numbers and widths. Assumes inclusion by bare name.
*/
`ifndef IRQ_VEC_CONSTS_SVH
`define IRQ_VEC_CONSTS_SVH

`define REG_ADDR_W 4
`define REG_DATA_W 16
`define FLAG_W 14
`define TRAP_W 5
`define OFFSET_W 7
`define PIN_W 6
`define SHARE_W 4

`define ADDR_FLAGS 4'h0
`define ADDR_ENABLES 4'h1
`define ADDR_SHARE 4'h2
`define ADDR_TRAP 4'h3
`define ADDR_VECTOR 4'h4

`define FLAGS_RESET 14'h0000
`define ENABLES_RESET 14'h0000
`define SHARE_RESET 4'h0

`define BIT_EXT0 0
`define BIT_EXT1 1
`define BIT_EXT2 2
`define BIT_TIMER 3
`define BIT_S0RX 4
`define BIT_S0TX 5
`define BIT_S2RX 6
`define BIT_S2TX 7
`define BIT_EXT3 8
`define BIT_HOST 9
`define BIT_S1RX 10
`define BIT_S1TX 11
`define BIT_DMA4 12
`define BIT_DMA5 13

`define SHARE_S2RX 0
`define SHARE_S2TX 1
`define SHARE_S1RX 2
`define SHARE_S1TX 3

`define PIN_NMI 4
`define PIN_RESET 5

`define TRAP_RESET 5'h00
`define TRAP_NMI 5'h01
`define TRAP_SOFT_FIRST 5'h02
`define TRAP_SOFT_LAST 5'h0F
`define TRAP_HW_BASE 5'h10
`define TRAP_LAST 5'h1D
`define OFFSET_SHIFT_PAD 2'h0

`endif

// ---- irq_vec_pkg.sv ----
/*
 Types of the interrupt vector and mask unit. Assumes irq_vec_consts.svh
 is on the include path.
*/
`default_nettype none
`include "irq_vec_consts.svh"

package irq_vec_pkg;
   typedef logic [`TRAP_W-1:0] trap_t;
   typedef logic [`OFFSET_W-1:0] offset_t;
   typedef logic [`REG_DATA_W-1:0] word_t;
   typedef logic [`REG_ADDR_W-1:0] addr_t;

   typedef struct packed {
      logic [`PIN_W-1:0] sync1;
      logic [`PIN_W-1:0] sync2;
      logic [`PIN_W-1:0] prev;
      logic [`FLAG_W-1:0] flags;
      logic [`FLAG_W-1:0] enables;
      logic [`SHARE_W-1:0] share;
      logic rst_pend;
      logic nmi_pend;
      logic soft_pend;
      trap_t soft_trap;
      logic vec_valid;
      trap_t vec_trap;
      offset_t vec_offset;
      logic irq_out;
      word_t rdata;
   } state_t;
endpackage : irq_vec_pkg

`default_nettype wire

// ---- dsp_interrupt_vector_mask_unit.sv ----
/*
 Interrupt vector and mask unit of a fixed-point DSP core: flag and enable
 registers, source sharing, trap request and fixed-priority vectoring.
 Assumes pins are asynchronous and active high, peripheral event inputs are
 one-cycle pulses on clk_sys, and the core answers a request with core_ack.
*/
// The implementer's own choices: the plain strobed port and the placing of the registers.
// Operation
// - The vector for trap K lies at offset 4*K, K 0..29, traps 2..15 being software only.
// - Reset is trap 0 at offset 00 with top priority, the nonmaskable interrupt trap 1 next.
// - Maskable interrupts rank by trap number, trap 16 highest, trap 29 lowest.
// - Trap 22 serves serial port 2 receive, or DMA channel 0 when shared.
// - Trap 23 serves serial port 2 transmit, or DMA channel 1 when shared.
// - Traps 26 and 27 serve serial port 1 receive and transmit, or DMA channels 2 and 3.
// - Trap 28 serves DMA channel 4, trap 29 DMA channel 5, traps 30 and 31 are unused.
// - Flags and enables share one 16-bit layout, one bit per maskable source.
// - Bits 0..2 are external interrupts 0..2 and bit 3 the timer.
// - Bits 4,5 are serial port 0 receive and transmit, bits 6,7 serial port 2 or DMA 0,1.
// - Bit 8 is external interrupt 3 and bit 9 the host port interrupt.
// - Bits 10,11 are serial port 1 or DMA 2,3, bits 12,13 DMA channels 4 and 5.
// - Bits 15 and 14 are reserved and read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "irq_vec_consts.svh"

module dsp_interrupt_vector_mask_unit (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reset_pin,
   input wire logic nmi_pin,
   input wire logic ext_irq_zero,
   input wire logic ext_irq_one,
   input wire logic ext_irq_two,
   input wire logic ext_irq_three,
   input wire logic timer_irq,
   input wire logic serial0_rx_irq,
   input wire logic serial0_tx_irq,
   input wire logic serial1_rx_irq,
   input wire logic serial1_tx_irq,
   input wire logic serial2_rx_irq,
   input wire logic serial2_tx_irq,
   input wire logic host_port_irq,
   input wire logic dma_ch0_irq,
   input wire logic dma_ch1_irq,
   input wire logic dma_ch2_irq,
   input wire logic dma_ch3_irq,
   input wire logic dma_ch4_irq,
   input wire logic dma_ch5_irq,
   input wire irq_vec_pkg::addr_t reg_addr,
   input wire irq_vec_pkg::word_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output irq_vec_pkg::word_t reg_rdata,
   input wire logic core_ack,
   output logic core_req,
   output irq_vec_pkg::trap_t core_trap,
   output irq_vec_pkg::offset_t core_offset,
   output logic irq_level
);
   import irq_vec_pkg::*;

   state_t st;
   state_t st_next;
   logic [`PIN_W-1:0] pin_edge;
   logic [`FLAG_W-1:0] set_mask;
   logic [`FLAG_W-1:0] clr_mask;
   logic [`FLAG_W-1:0] pending;
   trap_t wr_trap;
   logic taken;

   always_comb begin
      st_next = st;
      // Pins cross into clk_sys; only sync2 and prev feed the edge detect
      st_next.sync1 = {reset_pin, nmi_pin, ext_irq_three, ext_irq_two, ext_irq_one,
                       ext_irq_zero};
      st_next.sync2 = st.sync1;
      st_next.prev = st.sync2;
      pin_edge = st.sync2 & ~st.prev;
      taken = core_ack & st.vec_valid;
      wr_trap = reg_wdata[`TRAP_W-1:0];

      set_mask = '0;
      set_mask[`BIT_EXT0] = pin_edge[`BIT_EXT0];
      set_mask[`BIT_EXT1] = pin_edge[`BIT_EXT1];
      set_mask[`BIT_EXT2] = pin_edge[`BIT_EXT2];
      set_mask[`BIT_TIMER] = timer_irq;
      set_mask[`BIT_S0RX] = serial0_rx_irq;
      set_mask[`BIT_S0TX] = serial0_tx_irq;
      set_mask[`BIT_S2RX] = st.share[`SHARE_S2RX] ? dma_ch0_irq : serial2_rx_irq;
      set_mask[`BIT_S2TX] = st.share[`SHARE_S2TX] ? dma_ch1_irq : serial2_tx_irq;
      set_mask[`BIT_EXT3] = pin_edge[3];
      set_mask[`BIT_HOST] = host_port_irq;
      set_mask[`BIT_S1RX] = st.share[`SHARE_S1RX] ? dma_ch2_irq : serial1_rx_irq;
      set_mask[`BIT_S1TX] = st.share[`SHARE_S1TX] ? dma_ch3_irq : serial1_tx_irq;
      set_mask[`BIT_DMA4] = dma_ch4_irq;
      set_mask[`BIT_DMA5] = dma_ch5_irq;
      // Software may force a maskable trap by its number
      if (reg_wr && reg_addr == `ADDR_TRAP) begin
         for (int i = 0; i < `FLAG_W; i++) begin
            if (wr_trap == trap_t'(`TRAP_HW_BASE + i)) begin
               set_mask[i] = 1'b1;
            end
         end
      end

      clr_mask = '0;
      if (reg_wr && reg_addr == `ADDR_FLAGS) begin
         clr_mask = reg_wdata[`FLAG_W-1:0];
      end
      if (taken) begin
         for (int i = 0; i < `FLAG_W; i++) begin
            if (st.vec_trap == trap_t'(`TRAP_HW_BASE + i)) begin
               clr_mask[i] = 1'b1;
            end
         end
      end
      // Clear first, then set: an event in the clearing cycle survives
      st_next.flags = (st.flags & ~clr_mask) | set_mask;

      if (reg_wr && reg_addr == `ADDR_ENABLES) begin
         st_next.enables = reg_wdata[`FLAG_W-1:0];
      end
      if (reg_wr && reg_addr == `ADDR_SHARE) begin
         st_next.share = reg_wdata[`SHARE_W-1:0];
      end

      if (taken && st.vec_trap == `TRAP_RESET) begin
         st_next.rst_pend = 1'b0;
      end
      if (taken && st.vec_trap == `TRAP_NMI) begin
         st_next.nmi_pend = 1'b0;
      end
      if (taken && st.soft_pend && st.vec_trap == st.soft_trap) begin
         st_next.soft_pend = 1'b0;
      end
      if (pin_edge[`PIN_RESET]) begin
         st_next.rst_pend = 1'b1;
      end
      if (pin_edge[`PIN_NMI]) begin
         st_next.nmi_pend = 1'b1;
      end
      if (reg_wr && reg_addr == `ADDR_TRAP) begin
         if (wr_trap == `TRAP_RESET) begin
            st_next.rst_pend = 1'b1;
         end else if (wr_trap == `TRAP_NMI) begin
            st_next.nmi_pend = 1'b1;
         end else if (wr_trap >= `TRAP_SOFT_FIRST && wr_trap <= `TRAP_SOFT_LAST) begin
            // Software traps bypass masking and rank behind a pending reset or NMI only: taken as written
            st_next.soft_pend = 1'b1;
            st_next.soft_trap = wr_trap;
         end
      end

      // Vectoring on next state, so an acknowledged source never shows twice
      pending = st_next.flags & st_next.enables;
      st_next.vec_valid = 1'b1;
      st_next.vec_trap = `TRAP_RESET;
      if (st_next.rst_pend) begin
         st_next.vec_trap = `TRAP_RESET;
      end else if (st_next.nmi_pend) begin
         st_next.vec_trap = `TRAP_NMI;
      end else if (st_next.soft_pend) begin
         st_next.vec_trap = st_next.soft_trap;
      end else if (pending != '0) begin
         for (int i = `FLAG_W - 1; i >= 0; i--) begin
            if (pending[i]) begin
               st_next.vec_trap = trap_t'(`TRAP_HW_BASE + i);
            end
         end
      end else begin
         st_next.vec_valid = 1'b0;
      end
      st_next.vec_offset = {st_next.vec_trap, `OFFSET_SHIFT_PAD};
      st_next.irq_out = |pending;

      st_next.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            `ADDR_FLAGS: st_next.rdata = {2'h0, st.flags};
            `ADDR_ENABLES: st_next.rdata = {2'h0, st.enables};
            `ADDR_SHARE: st_next.rdata = {12'h000, st.share};
            `ADDR_TRAP: st_next.rdata = {10'h000, st.soft_pend, st.soft_trap};
            `ADDR_VECTOR: st_next.rdata = {st.vec_valid, 8'h00, st.vec_offset};
            default: st_next.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.flags <= `FLAGS_RESET;
         st.enables <= `ENABLES_RESET;
         st.share <= `SHARE_RESET;
      end else begin
         st <= st_next;
      end
   end

   assign core_req = st.vec_valid;
   assign core_trap = st.vec_trap;
   assign core_offset = st.vec_offset;
   assign irq_level = st.irq_out;
   assign reg_rdata = st.rdata;

   // Helper for the ranking check: enabled flags better than the shown one
   logic [`FLAG_W-1:0] better_pending;
   always_comb begin
      better_pending = '0;
      for (int i = 0; i < `FLAG_W; i++) begin
         if (core_trap > trap_t'(`TRAP_HW_BASE + i)) begin
            better_pending[i] = st.flags[i] & st.enables[i];
         end
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_read_flags;
      reg_rd && reg_addr == `ADDR_FLAGS;
   endsequence

   sequence s_dma0_shared;
      dma_ch0_irq && st.share[`SHARE_S2RX];
   endsequence

   sequence s_serial2_tx_default;
      serial2_tx_irq && !st.share[`SHARE_S2TX];
   endsequence

   sequence s_ext0_rise;
      $rose(ext_irq_zero);
   endsequence

   sequence s_dma5_taken;
      core_ack && core_req && core_trap == `TRAP_LAST && !dma_ch5_irq && !reg_wr;
   endsequence

   chk_offset_four_k: assert property (
      core_req |-> core_offset == {core_trap, 2'b00} && core_trap <= `TRAP_LAST)
      else $error("vector offset is not four times the trap number");

   chk_reset_wins: assert property (
      st.rst_pend |-> core_req && core_trap == 5'h00)
      else $error("pending reset not vectored to trap 0");

   chk_nmi_second: assert property (
      st.nmi_pend && !st.rst_pend |-> core_req && core_trap == 5'h01)
      else $error("pending nmi not vectored to trap 1");

   chk_hw_ranking: assert property (
      core_req && core_trap >= 5'h10 |-> better_pending == '0)
      else $error("a better pending source was passed over");

   chk_dma0_share: assert property (
      s_dma0_shared |=> st.flags[6])
      else $error("shared dma channel 0 did not set bit 6");

   chk_serial2_tx: assert property (
      s_serial2_tx_default |=> st.flags[7])
      else $error("serial port 2 transmit did not set bit 7");

   chk_flag_sticky: assert property (
      st.flags[`BIT_DMA5] && !reg_wr && !core_ack |=> st.flags[`BIT_DMA5])
      else $error("flag dropped without a clear or acknowledge");

   chk_mask_gates: assert property (
      irq_level |-> $past(st_next.flags & st_next.enables) != '0 && core_req)
      else $error("interrupt level high with nothing enabled pending");

   chk_reserved_zero: assert property (
      s_read_flags |=> reg_rdata[15:14] == 2'b00)
      else $error("reserved flag bits read nonzero");

   // Two sync flops plus edge detect: flag shows on the third edge
   chk_ext0_latency: assert property (
      s_ext0_rise |-> ##3 st.flags[`BIT_EXT0])
      else $error("external interrupt 0 edge did not set bit 0");

   chk_soft_trap_vec: assert property (
      st.soft_pend && !st.rst_pend && !st.nmi_pend |-> core_req && core_trap == st.soft_trap)
      else $error("pending software trap not vectored");

   chk_timer_bit: assert property (
      timer_irq |=> st.flags[`BIT_TIMER])
      else $error("timer event did not set bit 3");

   chk_serial0_rx: assert property (
      serial0_rx_irq |=> st.flags[`BIT_S0RX])
      else $error("serial port 0 receive did not set bit 4");

   chk_host_bit: assert property (
      host_port_irq |=> st.flags[`BIT_HOST])
      else $error("host port event did not set bit 9");

   chk_dma2_share: assert property (
      dma_ch2_irq && st.share[`SHARE_S1RX] |=> st.flags[`BIT_S1RX])
      else $error("shared dma channel 2 did not set bit 10");

   chk_dma4_bit: assert property (
      dma_ch4_irq |=> st.flags[`BIT_DMA4])
      else $error("dma channel 4 did not set bit 12");

   chk_ack_clears: assert property (
      s_dma5_taken |=> !st.flags[`BIT_DMA5])
      else $error("acknowledged flag was not cleared");

   chk_enable_write: assert property (
      reg_wr && reg_addr == `ADDR_ENABLES |=> st.enables == $past(reg_wdata[`FLAG_W-1:0]))
      else $error("enable register write did not land");

endmodule : dsp_interrupt_vector_mask_unit

`default_nettype wire

// ---- core_model.sv ----
/*
 Behavioural CPU core that takes vectors from the interrupt unit.
 Assumes one clk_sys domain and an active high asynchronous rst.
*/
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ack_on,
   input wire logic [3:0] ack_wait,
   input wire logic core_req,
   input wire irq_vec_pkg::trap_t core_trap,
   output logic core_ack,
   output irq_vec_pkg::trap_t taken_trap,
   output logic [7:0] taken_cnt
);
   import irq_vec_pkg::*;
   logic [3:0] wait_reg;
   // Acks only a standing request; a slow core lets a better vector overtake
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         core_ack <= 1'b0;
         wait_reg <= 4'h0;
         taken_trap <= 5'h00;
         taken_cnt <= 8'h00;
      end else if (core_ack) begin
         core_ack <= 1'b0;
         wait_reg <= 4'h0;
         taken_trap <= core_trap;
         taken_cnt <= taken_cnt + 8'h01;
      end else if (ack_on && core_req) begin
         if (wait_reg >= ack_wait) begin
            core_ack <= 1'b1;
         end else begin
            wait_reg <= wait_reg + 4'h1;
         end
      end else begin
         wait_reg <= 4'h0;
      end
   end
endmodule : core_model
`default_nettype wire

// ---- testbench.sv ----
/*
 Self-checking bench of the interrupt vector and mask unit.
 Assumes the design files and core_model.sv are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import irq_vec_pkg::*;
   typedef struct packed {logic [4:0] idx; logic [3:0] share; word_t flags;} row_t;
   logic clk_sys, rst, reset_pin, nmi_pin, reg_wr, reg_rd, core_ack, core_req, irq_level;
   logic ack_on;
   logic [3:0] ack_wait;
   logic [17:0] src;
   logic [7:0] taken_cnt;
   addr_t reg_addr;
   word_t reg_wdata, reg_rdata, d;
   trap_t core_trap, taken_trap;
   offset_t core_offset;
   int miscompares, compares, cycles, want;
   row_t rows [20];
   dsp_interrupt_vector_mask_unit dut (.clk_sys, .rst, .reset_pin, .nmi_pin,
      .ext_irq_zero(src[0]), .ext_irq_one(src[1]), .ext_irq_two(src[2]), .timer_irq(src[3]),
      .serial0_rx_irq(src[4]), .serial0_tx_irq(src[5]), .serial2_rx_irq(src[6]),
      .serial2_tx_irq(src[7]), .ext_irq_three(src[8]), .host_port_irq(src[9]),
      .serial1_rx_irq(src[10]), .serial1_tx_irq(src[11]), .dma_ch4_irq(src[12]),
      .dma_ch5_irq(src[13]), .dma_ch0_irq(src[14]), .dma_ch1_irq(src[15]),
      .dma_ch2_irq(src[16]), .dma_ch3_irq(src[17]), .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .core_ack, .core_req, .core_trap, .core_offset, .irq_level);
   core_model partner (.clk_sys, .rst, .ack_on, .ack_wait, .core_req, .core_trap,
      .core_ack, .taken_trap, .taken_cnt);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic conclude();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic cmp(word_t g, word_t e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task automatic wr(addr_t a, word_t v);
      @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge clk_sys) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(addr_t a, output word_t v);
      @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk_sys) reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic pulse(logic [17:0] m);
      @(posedge clk_sys) src <= m;
      @(posedge clk_sys) src <= 18'h00000;
      repeat (3) @(posedge clk_sys);
   endtask : pulse
   // Pending word is flags masked by enables; lowest bit wins
   task automatic check_vec(word_t p);
      word_t t;
      t = 16'h0000;
      for (int b = 13; b >= 0; b--) if (p[b]) t = 16'h0010 + 16'(b);
      #1 cmp(word_t'(irq_level), word_t'(p != 16'h0000));
      cmp(word_t'(core_req), word_t'(p != 16'h0000));
      cmp(word_t'(core_trap), t);
      cmp(word_t'(core_offset), t << 2);
   endtask : check_vec
   task automatic set_ack(logic on, logic [3:0] w);
      @(posedge clk_sys) {ack_on, ack_wait} <= {on, w};
   endtask : set_ack
   task automatic wait_taken(word_t t);
      want++;
      for (int i = 0; i < 60 && taken_cnt != want; i++) @(posedge clk_sys);
      #1 cmp(word_t'(taken_trap), t);
      cmp(word_t'(taken_cnt), word_t'(want));
   endtask : wait_taken
   initial begin
      {rst, reset_pin, nmi_pin, reg_wr, reg_rd, ack_on} = 6'h21;
      {src, reg_addr, reg_wdata, ack_wait} = '0;
      ack_on = 1'b0;
      rows = '{'{5'h00,4'h0,16'h0001}, '{5'h01,4'h0,16'h0002}, '{5'h02,4'h0,16'h0004},
         '{5'h03,4'h0,16'h0008}, '{5'h04,4'h0,16'h0010}, '{5'h05,4'h0,16'h0020},
         '{5'h06,4'h0,16'h0040}, '{5'h07,4'h0,16'h0080}, '{5'h08,4'h0,16'h0100},
         '{5'h09,4'h0,16'h0200}, '{5'h0A,4'h0,16'h0400}, '{5'h0B,4'h0,16'h0800},
         '{5'h0C,4'h0,16'h1000}, '{5'h0D,4'h0,16'h2000}, '{5'h0E,4'hF,16'h0040},
         '{5'h0F,4'hF,16'h0080}, '{5'h10,4'hF,16'h0400}, '{5'h11,4'hF,16'h0800},
         '{5'h0E,4'h0,16'h0000}, '{5'h06,4'hF,16'h0000}};
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rd(4'h0, d); cmp(d, 16'h0000);
      rd(4'h1, d); cmp(d, 16'h0000);
      wr(4'h1, 16'hFFFF); rd(4'h1, d); cmp(d, 16'h3FFF);
      wr(4'hF, 16'h0000); rd(4'hF, d); cmp(d, 16'h0000);
      rd(4'h1, d); cmp(d, 16'h3FFF);
      foreach (rows[r]) begin
         wr(4'h2, {12'h000, rows[r].share});
         pulse(18'h00001 << rows[r].idx);
         rd(4'h0, d); cmp(d, rows[r].flags);
         check_vec(rows[r].flags);
         wr(4'h0, rows[r].flags);
         check_vec(16'h0000);
      end
      wr(4'h2, 16'h0000);
      wr(4'h1, 16'h0000); pulse(18'h00008);
      rd(4'h0, d); cmp(d, 16'h0008);
      check_vec(16'h0000);
      wr(4'h1, 16'h0008); check_vec(16'h0008);
      wr(4'h1, 16'h3FFF); wr(4'h0, 16'h0008);
      pulse(18'h02001); check_vec(16'h2001);
      set_ack(1'b1, 4'h3); wait_taken(16'h0010); wait_taken(16'h001D);
      set_ack(1'b0, 4'h0); check_vec(16'h0000);
      rd(4'h0, d); cmp(d, 16'h0000);
      @(posedge clk_sys) {reset_pin, nmi_pin} <= 2'h3;
      repeat (4) @(posedge clk_sys);
      {reset_pin, nmi_pin} <= 2'h0;
      repeat (4) @(posedge clk_sys);
      #1 cmp({core_req, 3'h0, core_trap, core_offset}, 16'h8000);
      set_ack(1'b1, 4'h0); wait_taken(16'h0000); wait_taken(16'h0001);
      set_ack(1'b0, 4'h0);
      wr(4'h3, 16'h0005); wr(4'h3, 16'h001E); wr(4'h3, 16'h001D);
      #1 cmp({core_req, 3'h0, core_trap, core_offset}, 16'h8294);
      rd(4'h4, d); cmp(d, 16'h8014);
      rd(4'h0, d); cmp(d, 16'h2000);
      set_ack(1'b1, 4'h1); wait_taken(16'h0005); wait_taken(16'h001D);
      check_vec(16'h0000);
      // Reset in mid-run with a flag pending and enabled
      set_ack(1'b0, 4'h0);
      wr(4'h1, 16'h0008);
      pulse(18'h00008);
      check_vec(16'h0008);
      @(posedge clk_sys) rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      #1 cmp({core_req, irq_level, core_trap, core_offset, 2'h0}, 16'h0000);
      rd(4'h0, d);
      cmp(d, 16'h0000);
      rd(4'h1, d);
      cmp(d, 16'h0000);
      conclude();
   end
endmodule : testbench
`default_nettype wire
